// ### hdl/rgrf_regfile.sv
// General-purpose register file with scoreboard
`timescale 1ns/1ps
`default_nettype none
`include "rgrf_map.svh"
// Notes on behaviour
// - Thirty-one writable 32-bit registers, 5-bit index
// - Index zero reads zero, writes dropped
// - Odd register holds sign and exponent
// - Pair of registers zero and one unusable
// - Scoreboard set at issue, cleared at writeback
// - Stall while a read source is pending
// - Sub-words sign-extended or zero-filled
// - 64-bit operand accessed as even/odd pair
// - Words stored raw, no type tag
module rgrf_regfile
  import rgrf_pkg::*;
(
  input  wire logic        clk_sys_in,     // 20 MHz clock
  input  wire logic        reset_in,       // Synchronous reset, active high
  input  wire logic [4:0]  rd_a_idx_in,    // Read port A index
  input  wire logic [4:0]  rd_b_idx_in,    // Read port B index
  input  wire logic        rd_a_use_in,    // Port A used by issuing instr
  input  wire logic        rd_b_use_in,    // Port B used by issuing instr
  input  wire logic        rd_pair_in,     // Port A reads a 64-bit pair
  output logic      [31:0] rd_a_data_out,  // Port A word or pair low half
  output logic      [31:0] rd_a_hi_out,    // Port A pair high half
  output logic      [31:0] rd_b_data_out,  // Port B word
  output logic             rd_a_sign_out,  // Sign bit of port A value
  output logic      [7:0]  rd_a_exp_out,   // Exponent field of port A value
  input  wire logic        issue_in,       // Instruction issue attempt
  input  wire logic        issue_dst_in,   // Issuing instr has a destination
  input  wire logic [4:0]  issue_idx_in,   // Destination index
  input  wire logic        issue_pair_in,  // Destination is a pair
  output logic             stall_out,      // Issue blocked by pending source
  output logic             pair_err_out,   // Pair access aimed at pair 0/1
  input  wire logic        wr_en_in,       // Writeback strobe
  input  wire logic [4:0]  wr_idx_in,      // Writeback index
  input  wire logic [31:0] wr_data_in,     // Writeback word or pair low half
  input  wire logic [31:0] wr_hi_in,       // Pair high half
  input  wire logic        wr_pair_in,     // Writeback is a pair
  input  wire logic [1:0]  wr_size_in,     // Byte, half or word
  input  wire logic        wr_signed_in,   // Signed sub-word
  output logic      [31:0] pending_out     // Scoreboard flags
);
  logic [31:0] regs_r [`RGRF_NUM_REGS];   // Storage, raw bits
  logic [31:0] sb_r;                      // Scoreboard flags
  logic [31:0] sb_nxt;                    // Next scoreboard value
  logic [31:0] wr_ext;                    // Extended write data
  logic [4:0]  a_even;                    // Pair base of port A
  logic [4:0]  a_odd;                     // Odd half of port A
  logic [4:0]  w_even;                    // Pair base of write
  logic [4:0]  w_odd;                     // Odd half of write
  logic [4:0]  i_even;                    // Pair base of issue
  logic        a_bad;                     // Port A pair illegal
  logic        w_bad;                     // Write pair illegal
  logic        i_bad;                     // Issue pair illegal
  logic        src_busy;                  // Some source pending
  logic        issue_ok;                  // Issue accepted

  // Sub-word extension
  rgrf_extend u_ext (
    .data_in   (wr_data_in),
    .size_in   (wr_size_in),
    .signed_in (wr_signed_in),
    .data_out  (wr_ext)
  );

  // Pair base is the even index; odd half holds sign and exponent
  assign a_even = {rd_a_idx_in[4:1], 1'b0};
  assign a_odd  = {rd_a_idx_in[4:1], 1'b1};
  assign w_even = {wr_idx_in[4:1], 1'b0};
  assign w_odd  = {wr_idx_in[4:1], 1'b1};
  assign i_even = {issue_idx_in[4:1], 1'b0};
  // Lowest pair refused for 64-bit use
  assign a_bad = rd_pair_in & (a_even == `RGRF_ZERO_IDX);
  assign w_bad = wr_pair_in & (w_even == `RGRF_ZERO_IDX);
  assign i_bad = issue_pair_in & (i_even == `RGRF_ZERO_IDX);
  assign pair_err_out = (rd_a_use_in & a_bad) | (issue_in & i_bad) | (wr_en_in & w_bad);

  // Stall when a used source (or its pair partner) is pending
  always_comb begin
    src_busy = 1'b0;
    if (rd_a_use_in) begin
      src_busy = rd_pair_in ? (sb_r[a_even] | sb_r[a_odd]) : sb_r[rd_a_idx_in];
    end
    if (rd_b_use_in & sb_r[rd_b_idx_in]) begin
      src_busy = 1'b1;
    end
  end
  assign stall_out = issue_in & src_busy;
  assign issue_ok  = issue_in & ~src_busy & issue_dst_in & ~i_bad;

  // Read ports, index zero reads zero
  assign rd_a_data_out = a_bad ? `RGRF_ZERO_WORD :
                         regs_r[rd_pair_in ? a_even : rd_a_idx_in];
  assign rd_a_hi_out   = (rd_pair_in & ~a_bad) ? regs_r[a_odd] : `RGRF_ZERO_WORD;
  assign rd_b_data_out = regs_r[rd_b_idx_in];
  // Sign and exponent from the word, or from odd half for a pair
  assign rd_a_sign_out = rd_pair_in ? rd_a_hi_out[`RGRF_SIGN_BIT] :
                         rd_a_data_out[`RGRF_SIGN_BIT];
  assign rd_a_exp_out  = rd_pair_in ? rd_a_hi_out[`RGRF_EXP_HI:`RGRF_EXP_LO] :
                         rd_a_data_out[`RGRF_EXP_HI:`RGRF_EXP_LO];

  // Scoreboard: clear on writeback, set at issue; set wins
  always_comb begin
    sb_nxt = sb_r;
    if (wr_en_in & ~w_bad) begin
      if (wr_pair_in) begin
        sb_nxt[w_even] = 1'b0;
        sb_nxt[w_odd]  = 1'b0;
      end else begin
        sb_nxt[wr_idx_in] = 1'b0;
      end
    end
    if (issue_ok) begin
      sb_nxt[issue_idx_in] = 1'b1;
      if (issue_pair_in) begin
        sb_nxt[i_even]               = 1'b1;
        sb_nxt[{i_even[4:1], 1'b1}]  = 1'b1;
      end
    end
    sb_nxt[0] = 1'b0;
  end

  // Scoreboard register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sb_r <= `RGRF_SB_RESET;
    end else begin
      sb_r <= sb_nxt;
    end
  end
  assign pending_out = sb_r;

  // Storage; entry zero constant, others written by writeback
  genvar g;
  generate
    for (g = 0; g < `RGRF_NUM_REGS; g++) begin : g_reg
      if (g == 0) begin : g_zero
        always_ff @(posedge clk_sys_in) begin
          regs_r[g] <= `RGRF_ZERO_WORD;
        end
      end else begin : g_rw
        always_ff @(posedge clk_sys_in) begin
          if (reset_in) begin
            regs_r[g] <= `RGRF_ZERO_WORD;
          end else if (wr_en_in & wr_pair_in & ~w_bad & (w_even == 5'(g))) begin
            regs_r[g] <= wr_data_in;
          end else if (wr_en_in & wr_pair_in & ~w_bad & (w_odd == 5'(g))) begin
            regs_r[g] <= wr_hi_in;
          end else if (wr_en_in & ~wr_pair_in & (wr_idx_in == 5'(g))) begin
            regs_r[g] <= wr_ext;
          end
        end
      end
    end
  endgenerate

  // Checks
  // Full-word writeback to a writable register
  sequence s_word_wr;
    wr_en_in && !wr_pair_in && wr_idx_in != `RGRF_ZERO_IDX && wr_size_in == 2'h2;
  endsequence
  // Pair writeback aimed at a legal pair
  sequence s_pair_wr;
    wr_en_in && wr_pair_in && !w_bad;
  endsequence
  // Issue with a destination held back by a pending source
  sequence s_held_issue;
    issue_in && issue_dst_in && stall_out;
  endsequence
  // Port B at index zero reads zero
  a_zero_reads: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    rd_b_idx_in == `RGRF_ZERO_IDX |-> rd_b_data_out == `RGRF_ZERO_WORD)
    else $error("zero register read nonzero");
  // Entry zero and its flag never leave zero
  a_zero_slot: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !sb_r[`RGRF_ZERO_IDX] && regs_r[`RGRF_ZERO_IDX] == `RGRF_ZERO_WORD)
    else $error("zero entry or flag changed");
  // Word writeback lands unchanged
  a_word_store: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_word_wr |=> regs_r[$past(wr_idx_in)] == $past(wr_data_in))
    else $error("word write not stored");
  // Pending port B source stalls issue
  a_stall_src: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    issue_in && rd_b_use_in && sb_r[rd_b_idx_in] |-> stall_out)
    else $error("no stall on pending source");
  // Pending odd half of a port A pair stalls issue
  a_stall_pair: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    issue_in && rd_a_use_in && rd_pair_in && sb_r[a_odd] |-> stall_out)
    else $error("no stall on pending pair half");
  // Held issue leaves its destination flag alone
  a_held_no_set: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_held_issue ##0 !sb_r[issue_idx_in] |=> !sb_r[$past(issue_idx_in)])
    else $error("stalled issue set a flag");
  // Accepted issue flags its destination
  a_sb_set: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    issue_ok && issue_idx_in != `RGRF_ZERO_IDX |=> sb_r[$past(issue_idx_in)])
    else $error("scoreboard not set at issue");
  // Word writeback drops its flag
  a_sb_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    wr_en_in && !wr_pair_in && !issue_ok |=> !sb_r[$past(wr_idx_in)])
    else $error("scoreboard not cleared");
  // Lowest pair never read as a unit
  a_pair_bad: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    rd_pair_in && rd_a_idx_in[4:1] == 4'h0 |-> rd_a_hi_out == `RGRF_ZERO_WORD)
    else $error("lowest pair read");
  // Used read of the lowest pair is reported
  a_pair_err_rd: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    rd_a_use_in && rd_pair_in && rd_a_idx_in[4:1] == 4'h0 |-> pair_err_out)
    else $error("lowest pair read not reported");
  // Both halves of a pair land on one edge
  a_pair_wr: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_pair_wr |=> regs_r[$past(w_odd)] == $past(wr_hi_in)
      && regs_r[$past(w_even)] == $past(wr_data_in))
    else $error("pair write incomplete");
  // Both flags of a written pair drop together
  a_pair_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_pair_wr ##0 !issue_ok |=> !sb_r[$past(w_even)] && !sb_r[$past(w_odd)])
    else $error("pair flags not cleared");
  // Signed byte copies its sign to the top
  a_sign_ext: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    wr_en_in && !wr_pair_in && wr_idx_in != `RGRF_ZERO_IDX && wr_size_in == 2'h0
      && wr_signed_in |=> regs_r[$past(wr_idx_in)][31] == $past(wr_data_in[7]))
    else $error("byte not sign-extended");
  // Unsigned half leaves the top half clear
  a_zero_fill: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    wr_en_in && !wr_pair_in && wr_idx_in != `RGRF_ZERO_IDX && wr_size_in == 2'h1
      && !wr_signed_in |=> regs_r[$past(wr_idx_in)][`RGRF_DATA_W-1:`RGRF_HALF_W] == 16'h0000)
    else $error("half not zero-filled");
endmodule : rgrf_regfile
`default_nettype wire

// ### hdl/rgrf_map.svh
// Constants for the general-purpose register file
`ifndef RGRF_MAP_SVH
`define RGRF_MAP_SVH
`define RGRF_NUM_REGS    32
`define RGRF_IDX_W       5
`define RGRF_DATA_W      32
`define RGRF_SIGN_BIT    31
`define RGRF_EXP_HI      30
`define RGRF_EXP_LO      23
`define RGRF_MANT_HI     22
`define RGRF_BYTE_W      8
`define RGRF_HALF_W      16
`define RGRF_ZERO_IDX    5'h00
`define RGRF_ZERO_WORD   32'h00000000
`define RGRF_SB_RESET    32'h00000000
`endif

// ### hdl/rgrf_pkg.sv
// Types for the general-purpose register file
`default_nettype none
package rgrf_pkg;
  // Width of a write from the pipeline or load unit
  typedef enum logic [1:0] {
    RGRF_SZ_BYTE,
    RGRF_SZ_HALF,
    RGRF_SZ_WORD
  } rgrf_size_e;
endpackage : rgrf_pkg
`default_nettype wire

// ### hdl/rgrf_extend.sv
// Sub-word extension of incoming write data
`timescale 1ns/1ps
`default_nettype none
`include "rgrf_map.svh"
module rgrf_extend
  import rgrf_pkg::*;
(
  input  wire logic [31:0] data_in,     // Raw data, value in low bits
  input  wire logic [1:0]  size_in,     // Byte, half or word
  input  wire logic        signed_in,   // Sign-extend when high
  output logic      [31:0] data_out     // Full 32-bit word
);
  // Sign or zero fill the upper bits
  always_comb begin
    case (rgrf_size_e'(size_in))
      RGRF_SZ_BYTE: data_out = {{(`RGRF_DATA_W-`RGRF_BYTE_W){signed_in &
                                 data_in[`RGRF_BYTE_W-1]}}, data_in[`RGRF_BYTE_W-1:0]};
      RGRF_SZ_HALF: data_out = {{(`RGRF_DATA_W-`RGRF_HALF_W){signed_in &
                                 data_in[`RGRF_HALF_W-1]}}, data_in[`RGRF_HALF_W-1:0]};
      default:      data_out = data_in;
    endcase
  end
endmodule : rgrf_extend
`default_nettype wire

// ### testbench/rgrf_pipe_model.sv
// Far-side model: pipeline writeback and load unit
`timescale 1ns/1ps
`default_nettype none
module rgrf_pipe_model (
  input  wire logic        clk_in,       // System clock
  output logic             wr_en_out,    // Writeback strobe
  output logic      [4:0]  wr_idx_out,   // Destination
  output logic      [31:0] wr_data_out,  // Word or low half
  output logic      [31:0] wr_hi_out,    // Pair high half
  output logic             wr_pair_out,  // Pair write
  output logic      [1:0]  wr_size_out,  // Size code
  output logic             wr_sgn_out    // Signed sub-word
);
  // Idle lines at time zero
  initial begin
    wr_en_out = 1'b0;
    {wr_idx_out, wr_data_out, wr_hi_out, wr_pair_out, wr_size_out, wr_sgn_out} = 73'h0;
  end
  // One writeback after d cycles of latency, entered at a falling edge
  task automatic wb(input logic [4:0] i, input logic [31:0] lo, input logic [31:0] hi,
                    input logic p, input logic [1:0] s, input logic g, input int d);
    repeat (d) @(negedge clk_in);
    {wr_idx_out, wr_data_out, wr_hi_out, wr_pair_out, wr_size_out, wr_sgn_out} =
      {i, lo, hi, p, s, g};
    wr_en_out = 1'b1;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    wr_data_out = ~lo;  // Released data scrambled
    wr_hi_out = ~hi;
  endtask : wb
endmodule : rgrf_pipe_model
`default_nettype wire

// ### testbench/risc_gp_register_file_tb.sv
// Self-checking bench for the general-purpose register file
`timescale 1ns/1ps
`default_nettype none
module risc_gp_register_file_tb;
  import rgrf_pkg::*;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, rd_a_use_in = 1'b0, rd_b_use_in = 1'b0;
  logic rd_pair_in = 1'b0, issue_in = 1'b0, issue_dst_in = 1'b0, issue_pair_in = 1'b0;
  logic [4:0] rd_a_idx_in = 5'h00, rd_b_idx_in = 5'h00, issue_idx_in = 5'h00, wr_idx_in, i;
  logic wr_en_in, wr_pair_in, wr_signed_in, rd_a_sign_out, stall_out, pair_err_out, g;
  logic [1:0] wr_size_in, s;
  logic [7:0] rd_a_exp_out;
  logic [31:0] wr_data_in, wr_hi_in, rd_a_data_out, rd_a_hi_out, rd_b_data_out, pending_out;
  logic [31:0] m [32];  // Expected contents
  logic [31:0] d, h, e;
  int fail_count = 0, n_tests = 0, n;
  always #25 clk_sys_in = ~clk_sys_in;  // 20 MHz
  rgrf_regfile dut_u (.clk_sys_in, .reset_in, .rd_a_idx_in, .rd_b_idx_in, .rd_a_use_in,
    .rd_b_use_in, .rd_pair_in, .rd_a_data_out, .rd_a_hi_out, .rd_b_data_out, .rd_a_sign_out,
    .rd_a_exp_out, .issue_in, .issue_dst_in, .issue_idx_in, .issue_pair_in, .stall_out,
    .pair_err_out, .wr_en_in, .wr_idx_in, .wr_data_in, .wr_hi_in, .wr_pair_in, .wr_size_in,
    .wr_signed_in, .pending_out);
  rgrf_pipe_model pm_u (.clk_in(clk_sys_in), .wr_en_out(wr_en_in), .wr_idx_out(wr_idx_in),
    .wr_data_out(wr_data_in), .wr_hi_out(wr_hi_in), .wr_pair_out(wr_pair_in),
    .wr_size_out(wr_size_in), .wr_sgn_out(wr_signed_in));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Counts, verdict, end of run
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Expected word after sub-word extension
  function automatic logic [31:0] ext(input logic [31:0] v, input logic [1:0] z, input logic q);
    if (z == 2'h0) return q ? {{24{v[7]}}, v[7:0]} : {24'h000000, v[7:0]};
    if (z == 2'h1) return q ? {{16{v[15]}}, v[15:0]} : {16'h0000, v[15:0]};
    return v;
  endfunction : ext
  // Present read indices and let outputs settle
  task automatic rd(input logic [4:0] a, input logic [4:0] b, input logic p);
    rd_a_idx_in = a;
    rd_b_idx_in = b;
    rd_pair_in = p;
    #1;
  endtask : rd
  // Writeback through the model, tracking expected contents
  task automatic wr(input logic [4:0] a, input logic [31:0] lo, input logic [31:0] hi,
                    input logic p, input int dly);
    pm_u.wb(a, lo, hi, p, s, g, dly);
    if (p && a[4:1] != 4'h0) {m[a | 5'h01], m[a & 5'h1E]} = {hi, lo};
    else if (!p && a != 5'h00) m[a] = ext(lo, s, g);
  endtask : wr
  // Main sequence
  initial begin
    void'($urandom(81669));
    foreach (m[k]) m[k] = 32'h00000000;
    repeat (8) @(negedge clk_sys_in);
    reset_in = 1'b0;
    chk(pending_out, 32'h00000000);
    // Word and sub-word writes, corner values first
    for (int k = 0; k < 60; k++) begin
      i = (k < 6) ? 5'(k) : 5'($urandom);
      d = (k < 6) ? 32'hA5A58080 : $urandom;
      s = (k < 6) ? 2'(k % 3) : 2'($urandom);
      g = (k < 6) ? 1'(k < 3) : 1'($urandom);
      wr(i, d, ~d, 1'b0, 1);
      rd(i, i, 1'b0);
      e = m[i];
      chk(rd_b_data_out, e);
      chk(rd_a_data_out, e);
      chk({23'h000000, rd_a_sign_out, rd_a_exp_out}, {23'h000000, e[31:23]});
      chk(rd_a_hi_out, 32'h00000000);
    end
    // Pair writes, read as a unit and high half as a word
    s = 2'h2;
    g = 1'b0;
    for (int k = 0; k < 8; k++) begin
      i = (k == 0) ? 5'h1E : 5'($urandom_range(15, 1) * 2);
      d = $urandom;
      h = (k == 0) ? 32'hFF800001 : $urandom;
      wr(i, d, h, 1'b1, 1 + k % 2);
      rd(i | 5'(k % 2), i + 5'h01, 1'b1);
      chk(rd_a_data_out, d);
      chk(rd_a_hi_out, h);
      chk(rd_b_data_out, h);
      chk({23'h000000, rd_a_sign_out, rd_a_exp_out}, {23'h000000, h[31:23]});
    end
    // Lowest pair refused on write, read and issue
    fork
      wr(5'h00, d, h, 1'b1, 1);
      begin
        @(negedge clk_sys_in);
        #1 chk(32'(pair_err_out), 32'h00000001);
      end
    join
    rd_a_use_in = 1'b1;
    rd(5'h01, 5'h01, 1'b1);
    chk(rd_b_data_out, m[1]);
    chk(rd_a_data_out, 32'h00000000);
    chk(rd_a_hi_out, 32'h00000000);
    chk(32'(pair_err_out), 32'h00000001);
    @(negedge clk_sys_in);
    rd_a_use_in = 1'b0;
    {issue_in, issue_dst_in, issue_pair_in, issue_idx_in} = {3'h7, 5'h00};
    #1 chk(32'(pair_err_out), 32'h00000001);
    @(negedge clk_sys_in);
    chk(pending_out & 32'h00000003, 32'h00000000);
    // Flag, stall against a slow writeback, stalled issue ignored
    {issue_pair_in, issue_idx_in} = {1'b0, 5'h05};
    @(negedge clk_sys_in);
    chk(pending_out & 32'h00000020, 32'h00000020);
    {issue_idx_in, rd_a_use_in, rd_a_idx_in, rd_pair_in} = {5'h09, 1'b1, 5'h05, 1'b0};
    {rd_b_use_in, rd_b_idx_in} = {1'b1, 5'h05};
    fork
      wr(5'h05, d, ~d, 1'b0, 3);
      repeat (3) begin
        #1 chk(32'(stall_out), 32'h00000001);
        chk(pending_out & 32'h00000200, 32'h00000000);
        @(negedge clk_sys_in);
      end
    join
    for (n = 0; n < 8 && stall_out !== 1'b0; n++) @(negedge clk_sys_in);
    if (n == 8) begin
      fail_count++;
      give_verdict();
    end
    chk(rd_a_data_out, d);
    chk(pending_out & 32'h00000020, 32'h00000000);
    // Pair issue sets both flags, a pair source stalls, pair writeback clears both
    {issue_pair_in, issue_idx_in, rd_a_use_in, rd_b_use_in} = {1'b1, 5'h06, 1'b0, 1'b0};
    @(negedge clk_sys_in);
    {issue_pair_in, issue_idx_in, rd_a_use_in} = {1'b0, 5'h0B, 1'b1};
    rd(5'h06, 5'h07, 1'b1);
    chk(32'(stall_out), 32'h00000001);
    chk(pending_out & 32'h000000C0, 32'h000000C0);
    wr(5'h06, d, h, 1'b1, 1);
    {issue_pair_in, issue_idx_in, rd_a_use_in} = {1'b1, 5'h0A, 1'b0};
    chk(pending_out & 32'h000008C0, 32'h00000000);
    // Reset in mid-run clears flags and stored words
    @(negedge clk_sys_in);
    chk(pending_out & 32'h00000C00, 32'h00000C00);
    {issue_in, reset_in} = 2'h1;
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'b0;
    rd(5'h06, 5'h07, 1'b1);
    chk(pending_out, 32'h00000000);
    chk(rd_a_data_out | rd_a_hi_out | rd_b_data_out, 32'h00000000);
    give_verdict();
  end
endmodule : risc_gp_register_file_tb
`default_nettype wire
